/* File: core/io_recovery_control_gap.sv */
// Link-side command strobe generator with recovery gap enforcement
`timescale 1ns/1ns
module io_recovery_control_gap
  import io_recovery_control_pkg::*;
#(
  parameter int CMD_CYC = IO_RECOVERY_CONTROL_CMD_CYC
) (
  input wire logic i_clk_isa,
  input wire logic i_rst,
  io_recovery_control_if.link bus,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic [15:0] o_isa_addr
);
  import io_recovery_control_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  io_recovery_control_lstate_t state_r, state_nxt;
  logic [IO_RECOVERY_CONTROL_CNT_W-1:0] cnt_r, cnt_nxt;
  logic req_s1_r, req_s2_r, req_s3_r;
  logic pend_r, pend_nxt;
  logic ack_r, ack_nxt;
  logic ior_n_r, ior_n_nxt;
  logic iow_n_r, iow_n_nxt;
  logic [15:0] addr_r, addr_nxt;

  // Gap in whole clocks from strobe rise to next strobe fall
  function automatic logic [IO_RECOVERY_CONTROL_CNT_W-1:0] gap_cyc(input logic wide, input logic sub, input logic [7:0] cfg);
    logic [IO_RECOVERY_CONTROL_CNT_W-1:0] extra;
    extra = '0;
    if (sub) begin
      extra = '0;
    end else if (wide) begin
      if (cfg[IO_RECOVERY_CONTROL_R16_EN_BIT]) begin
        extra = IO_RECOVERY_CONTROL_CNT_W'(cfg[IO_RECOVERY_CONTROL_R16_CNT_LSB +: IO_RECOVERY_CONTROL_R16_CNT_W]);
      end
    end else if (cfg[IO_RECOVERY_CONTROL_R8_EN_BIT]) begin
      extra = IO_RECOVERY_CONTROL_CNT_W'(cfg[IO_RECOVERY_CONTROL_R8_CNT_LSB +: IO_RECOVERY_CONTROL_R8_CNT_W]);
    end
    gap_cyc = IO_RECOVERY_CONTROL_GAP_MIN_CYC + extra;
  endfunction

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r | (req_s2_r ^ req_s3_r);
    ack_nxt = ack_r;
    ior_n_nxt = ior_n_r;
    iow_n_nxt = iow_n_r;
    addr_nxt = addr_r;
    case (state_r)
      IO_RECOVERY_CONTROL_L_IDLE: begin
        if (pend_r) begin
          pend_nxt = req_s2_r ^ req_s3_r;
          addr_nxt = bus.addr;
          ior_n_nxt = bus.wr;
          iow_n_nxt = ~bus.wr;
          cnt_nxt = IO_RECOVERY_CONTROL_CNT_W'(CMD_CYC - 1);
          state_nxt = IO_RECOVERY_CONTROL_L_CMD;
        end
      end
      IO_RECOVERY_CONTROL_L_CMD: begin
        if (cnt_r == '0) begin
          ior_n_nxt = 1'b1;
          iow_n_nxt = 1'b1;
          ack_nxt = ~ack_r;
          // Counting starts at the strobe rise; two cycles go to RECOV exit and IDLE
          // Config byte rides with the request and stays still until the ack, so no word crossing
          cnt_nxt = gap_cyc(bus.wide, bus.sub, bus.cfg) - IO_RECOVERY_CONTROL_CNT_W'(2);
          state_nxt = IO_RECOVERY_CONTROL_L_RECOV;
        end else begin
          cnt_nxt = cnt_r - IO_RECOVERY_CONTROL_CNT_W'(1);
        end
      end
      IO_RECOVERY_CONTROL_L_RECOV: begin
        if (cnt_r == '0) begin
          state_nxt = IO_RECOVERY_CONTROL_L_IDLE;
        end else begin
          cnt_nxt = cnt_r - IO_RECOVERY_CONTROL_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = IO_RECOVERY_CONTROL_L_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_isa or posedge i_rst) begin
    if (i_rst) begin
      state_r <= IO_RECOVERY_CONTROL_L_IDLE;
      cnt_r <= '0;
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      pend_r <= 1'b0;
      ack_r <= 1'b0;
      ior_n_r <= 1'b1;
      iow_n_r <= 1'b1;
      addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      req_s1_r <= bus.req_tgl;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      pend_r <= pend_nxt;
      ack_r <= ack_nxt;
      ior_n_r <= ior_n_nxt;
      iow_n_r <= iow_n_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign bus.ack_tgl = ack_r;
  assign o_ior_n = ior_n_r;
  assign o_iow_n = iow_n_r;
  assign o_isa_addr = addr_r;
endmodule

/* File: core/io_recovery_control_top.sv */
// I/O recovery timer: configuration registers, alias decode and ISA command pacing
`timescale 1ns/1ns
// Contract
// - Header type reads 80h at 0Eh, read-only
// - Recovery only for host 8/16-bit ISA I/O
// - Always at least 3.5 clocks between commands
// - Gap measured strobe rise to next fall
// - Programmed count adds whole clocks to gap
// - No extra delay for assembly sub-cycles
// - Recovery register at 4Ch resets to 4Dh
// - Alias bit clear maps 90-9Fh onto 80-8Fh
// - While aliasing, forward writes only, drop reads
// - 8-bit enable selects count bits 5:3
// - Alias bit set ignores ISA master accesses
// - Port 92h always distinct and forwarded
// - Alias bit set blocks fast-off timer reload; blocked only for 90-9Fh accesses, 92h excluded
module io_recovery_control_top
  import io_recovery_control_pkg::*;
#(
  parameter int CMD_CYC = io_recovery_control_pkg::IO_RECOVERY_CONTROL_CMD_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_clk_isa,
  input wire logic i_rst,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_io_req,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_wide,
  input wire logic i_io_sub,
  input wire logic i_isam_cmd,
  input wire logic [15:0] i_isam_addr,
  output logic [7:0] o_cfg_rdata,
  output logic o_io_busy,
  output logic o_io_done,
  output logic o_io_dropped,
  output logic o_fot_reload,
  output logic o_isam_claim,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic [15:0] o_isa_addr
);
  import io_recovery_control_pkg::*;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [7:0] rec_r, rec_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rec_nxt = rec_r;
    if (i_cfg_wr && (i_cfg_addr == IO_RECOVERY_CONTROL_REC_OFS)) begin
      rec_nxt = i_cfg_wdata;
    end
    // Writes to the header byte fall through and change nothing
    rdata_nxt = rdata_r;
    if (i_cfg_rd) begin
      case (i_cfg_addr)
        IO_RECOVERY_CONTROL_HDR_OFS: rdata_nxt = IO_RECOVERY_CONTROL_HDR_VAL;
        IO_RECOVERY_CONTROL_REC_OFS: rdata_nxt = rec_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rec_r <= IO_RECOVERY_CONTROL_REC_RST;
      rdata_r <= 8'h00;
    end else begin
      rec_r <= rec_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Host I/O request decode and hand-off to the link
  // ****************************************************************
  io_recovery_control_if bus();

  io_recovery_control_sstate_t st_r, st_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic drop_r, drop_nxt;
  logic fot_r, fot_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic wr_r, wr_nxt;
  logic wide_r, wide_nxt;
  logic sub_r, sub_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic ack_s1_r, ack_s2_r, ack_s3_r;
  logic in_alias;
  logic alias_off;

  assign alias_off = rec_r[IO_RECOVERY_CONTROL_ALIAS_BIT];
  assign in_alias = io_recovery_control_in_alias(i_io_addr);

  always_comb begin
    st_nxt = st_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    drop_nxt = 1'b0;
    fot_nxt = 1'b0;
    req_tgl_nxt = req_tgl_r;
    addr_nxt = addr_r;
    wr_nxt = wr_r;
    wide_nxt = wide_r;
    sub_nxt = sub_r;
    cfg_nxt = cfg_r;
    case (st_r)
      IO_RECOVERY_CONTROL_S_IDLE: begin
        if (i_io_req) begin
          fot_nxt = ~(in_alias && alias_off);
          if (in_alias && !alias_off && !i_io_wr) begin
            // Aliased reads end here without an ISA cycle
            done_nxt = 1'b1;
            drop_nxt = 1'b1;
          end else begin
            // Port 92h never matches the alias window, so it goes out as-is
            addr_nxt = (in_alias && !alias_off) ? (i_io_addr - IO_RECOVERY_CONTROL_ALIAS_SHIFT) : i_io_addr;
            wr_nxt = i_io_wr;
            wide_nxt = i_io_wide;
            sub_nxt = i_io_sub;
            cfg_nxt = rec_r;
            req_tgl_nxt = ~req_tgl_r;
            busy_nxt = 1'b1;
            st_nxt = IO_RECOVERY_CONTROL_S_WAIT;
          end
        end
      end
      IO_RECOVERY_CONTROL_S_WAIT: begin
        // Completion returns at the strobe rise; recovery runs on the link side
        if (ack_s2_r ^ ack_s3_r) begin
          done_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt = IO_RECOVERY_CONTROL_S_IDLE;
        end
      end
      default: begin
        busy_nxt = 1'b0;
        st_nxt = IO_RECOVERY_CONTROL_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= IO_RECOVERY_CONTROL_S_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      drop_r <= 1'b0;
      fot_r <= 1'b0;
      req_tgl_r <= 1'b0;
      addr_r <= 16'h0000;
      wr_r <= 1'b0;
      wide_r <= 1'b0;
      sub_r <= 1'b0;
      cfg_r <= IO_RECOVERY_CONTROL_REC_RST;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      drop_r <= drop_nxt;
      fot_r <= fot_nxt;
      req_tgl_r <= req_tgl_nxt;
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
      wide_r <= wide_nxt;
      sub_r <= sub_nxt;
      cfg_r <= cfg_nxt;
      ack_s1_r <= bus.ack_tgl;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  // Payload stays still while a toggle is in flight, so plain sampling is safe.
  // The config byte is copied with each request; a write mid-cycle applies to the next one.
  assign bus.req_tgl = req_tgl_r;
  assign bus.addr = addr_r;
  assign bus.wr = wr_r;
  assign bus.wide = wide_r;
  assign bus.sub = sub_r;
  assign bus.cfg = cfg_r;

  // ****************************************************************
  // ISA master decode of the alias window
  // ****************************************************************
  logic isam_s1_r, isam_s2_r, isam_s3_r;
  logic [15:0] isam_a1_r, isam_a2_r;
  logic claim_r, claim_nxt;

  always_comb begin
    claim_nxt = 1'b0;
    if (isam_s2_r && !isam_s3_r) begin
      claim_nxt = io_recovery_control_in_alias(isam_a2_r) && !alias_off;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      isam_s1_r <= 1'b0;
      isam_s2_r <= 1'b0;
      isam_s3_r <= 1'b0;
      isam_a1_r <= 16'h0000;
      isam_a2_r <= 16'h0000;
      claim_r <= 1'b0;
    end else begin
      isam_s1_r <= i_isam_cmd;
      isam_s2_r <= isam_s1_r;
      isam_s3_r <= isam_s2_r;
      isam_a1_r <= i_isam_addr;
      isam_a2_r <= isam_a1_r;
      claim_r <= claim_nxt;
    end
  end

  // ****************************************************************
  // Link-side strobe generator
  // ****************************************************************
  io_recovery_control_gap #(
    .CMD_CYC(CMD_CYC)
  ) u_gap (
    .i_clk_isa(i_clk_isa),
    .i_rst(i_rst),
    .bus(bus.link),
    .o_ior_n(o_ior_n),
    .o_iow_n(o_iow_n),
    .o_isa_addr(o_isa_addr)
  );

  assign o_cfg_rdata = rdata_r;
  assign o_io_busy = busy_r;
  assign o_io_done = done_r;
  assign o_io_dropped = drop_r;
  assign o_fot_reload = fot_r;
  assign o_isam_claim = claim_r;
endmodule

/* File: inc/io_recovery_control_if.sv */
// Request and completion handshake between the system and link domains
`timescale 1ns/1ns
interface io_recovery_control_if;
  logic req_tgl;
  logic ack_tgl;
  logic [15:0] addr;
  logic wr;
  logic wide;
  logic sub;
  logic [7:0] cfg;

  modport sys (output req_tgl, output addr, output wr, output wide, output sub, output cfg, input ack_tgl);
  modport link (input req_tgl, input addr, input wr, input wide, input sub, input cfg, output ack_tgl);
endinterface

/* File: inc/io_recovery_control_pkg.sv */
// Shared constants, types and decode helpers for the I/O recovery timer block
package io_recovery_control_pkg;

  // ****************************************************************
  // Configuration map
  // ****************************************************************
  localparam logic [7:0] IO_RECOVERY_CONTROL_HDR_OFS = 8'h0E;
  localparam logic [7:0] IO_RECOVERY_CONTROL_HDR_VAL = 8'h80;
  localparam logic [7:0] IO_RECOVERY_CONTROL_REC_OFS = 8'h4C;
  localparam logic [7:0] IO_RECOVERY_CONTROL_REC_RST = 8'h4D;

  // Fields of recovery_timer_register
  localparam int IO_RECOVERY_CONTROL_ALIAS_BIT = 7;
  localparam int IO_RECOVERY_CONTROL_R8_EN_BIT = 6;
  localparam int IO_RECOVERY_CONTROL_R8_CNT_LSB = 3;
  localparam int IO_RECOVERY_CONTROL_R8_CNT_W = 3;
  localparam int IO_RECOVERY_CONTROL_R16_EN_BIT = 2;
  localparam int IO_RECOVERY_CONTROL_R16_CNT_LSB = 0;
  localparam int IO_RECOVERY_CONTROL_R16_CNT_W = 2;

  // ****************************************************************
  // I/O address decode
  // ****************************************************************
  localparam logic [15:0] IO_RECOVERY_CONTROL_ALIAS_LO = 16'h0090;
  localparam logic [15:0] IO_RECOVERY_CONTROL_ALIAS_HI = 16'h009F;
  localparam logic [15:0] IO_RECOVERY_CONTROL_ALIAS_SHIFT = 16'h0010;
  localparam logic [15:0] IO_RECOVERY_CONTROL_PORT_SYSCTL = 16'h0092;

  // ****************************************************************
  // Timing, counted in link clocks
  // ****************************************************************
  localparam int IO_RECOVERY_CONTROL_GAP_MIN_HALF = 7;
  // A least time rounds up: 3.5 clocks becomes 4 whole clocks
  localparam logic [3:0] IO_RECOVERY_CONTROL_GAP_MIN_CYC = 4'((IO_RECOVERY_CONTROL_GAP_MIN_HALF + 1) / 2);
  localparam int IO_RECOVERY_CONTROL_CMD_CYC = 3;
  localparam int IO_RECOVERY_CONTROL_CNT_W = 4;

  typedef enum logic [1:0] {
    IO_RECOVERY_CONTROL_L_IDLE = 2'b00,
    IO_RECOVERY_CONTROL_L_CMD = 2'b01,
    IO_RECOVERY_CONTROL_L_RECOV = 2'b10
  } io_recovery_control_lstate_t;

  typedef enum logic [0:0] {
    IO_RECOVERY_CONTROL_S_IDLE = 1'b0,
    IO_RECOVERY_CONTROL_S_WAIT = 1'b1
  } io_recovery_control_sstate_t;

  // True for the page register alias window, port 92h excluded
  function automatic logic io_recovery_control_in_alias(input logic [15:0] addr);
    io_recovery_control_in_alias = (addr >= IO_RECOVERY_CONTROL_ALIAS_LO) && (addr <= IO_RECOVERY_CONTROL_ALIAS_HI) && (addr != IO_RECOVERY_CONTROL_PORT_SYSCTL);
  endfunction

endpackage

/* File: verif/io_recovery_control_isa_dev.sv */
// ISA side model: a peripheral timing the command gap, and an ISA master
`timescale 1ns/1ns
module io_recovery_control_isa_dev (
  input wire logic i_clk_isa,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic [15:0] i_isa_addr,
  input wire logic i_go,
  input wire logic [15:0] i_go_addr,
  output logic o_cmd = 1'b0,
  output logic [15:0] o_addr = 16'hA5A5,
  output logic [7:0] o_gap = 8'h00,
  output logic [15:0] o_last_addr = 16'h0000,
  output logic o_last_wr = 1'b0,
  output logic [7:0] o_n_cmd = 8'h00
);
  logic [7:0] cnt = 8'h00;
  logic was_idle = 1'b1;
  // Gap is the count of idle samples from strobe rise to next fall
  always @(posedge i_clk_isa) begin
    was_idle <= i_ior_n && i_iow_n;
    if (i_ior_n && i_iow_n) begin
      cnt <= cnt + 8'h01;
    end else if (was_idle) begin
      o_gap <= cnt;
      cnt <= 8'h00;
      o_last_addr <= i_isa_addr;
      o_last_wr <= !i_iow_n;
      o_n_cmd <= o_n_cmd + 8'h01;
    end
  end
  // Released address lines show a changed value, not the stale one
  always @(posedge i_go) begin
    @(posedge i_clk_isa);
    o_addr <= i_go_addr;
    @(posedge i_clk_isa);
    o_cmd <= 1'b1;
    repeat (6) @(posedge i_clk_isa);
    o_cmd <= 1'b0;
    o_addr <= ~i_go_addr;
  end
endmodule

/* File: verif/io_recovery_control_properties.sv */
// Port-level checker for the I/O recovery timer
`timescale 1ns/1ns
module io_recovery_control_chk (
  input wire logic i_clk_sys,
  input wire logic i_clk_isa,
  input wire logic i_rst,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic i_io_req,
  input wire logic [15:0] i_io_addr,
  input wire logic o_io_busy,
  input wire logic o_io_done,
  input wire logic o_io_dropped,
  input wire logic o_fot_reload,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_ior_n,
  input wire logic o_iow_n
);
  import io_recovery_control_pkg::*;
  logic idle;
  assign idle = o_ior_n && o_iow_n;
  // ****************************************************************
  // Link side
  // ****************************************************************
  property p_excl;
    @(posedge i_clk_isa) disable iff (i_rst) o_ior_n || o_iow_n;
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  // Four whole clocks stand in for the 3.5-clock minimum
  property p_gap;
    @(posedge i_clk_isa) disable iff (i_rst) $rose(idle) |-> idle [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("recovery gap short");
  property p_wid;
    @(posedge i_clk_isa) disable iff (i_rst) $fell(idle) |-> !idle [*3] ##1 idle;
  endproperty
  a_wid: assert property (p_wid) else $error("strobe width wrong");
  // ****************************************************************
  // System side
  // ****************************************************************
  property p_hdr;
    @(posedge i_clk_sys) disable iff (i_rst) i_cfg_rd && i_cfg_addr == 8'h0E |=> o_cfg_rdata == 8'h80;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header byte wrong");
  property p_drop;
    @(posedge i_clk_sys) disable iff (i_rst) o_io_dropped |-> o_io_done;
  endproperty
  a_drop: assert property (p_drop) else $error("drop without done");
  property p_fot92;
    @(posedge i_clk_sys) disable iff (i_rst) i_io_req && !o_io_busy && i_io_addr == 16'h0092 |=> o_fot_reload;
  endproperty
  a_fot92: assert property (p_fot92) else $error("no reload on 92h");
  property p_fwd92;
    @(posedge i_clk_sys) disable iff (i_rst) i_io_req && !o_io_busy && i_io_addr == 16'h0092 |=> !o_io_done [*2];
  endproperty
  a_fwd92: assert property (p_fwd92) else $error("92h not forwarded");
  property p_fwd;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_io_req && !o_io_busy && i_io_addr[15:4] == 12'h030 |=> o_io_busy && o_fot_reload;
  endproperty
  a_fwd: assert property (p_fwd) else $error("plain cycle not taken");
endmodule

bind io_recovery_control_top io_recovery_control_chk chk_u (.i_clk_sys(i_clk_sys), .i_clk_isa(i_clk_isa), .i_rst(i_rst), .i_cfg_rd(i_cfg_rd),
  .i_cfg_addr(i_cfg_addr), .i_io_req(i_io_req), .i_io_addr(i_io_addr), .o_io_busy(o_io_busy),
  .o_io_done(o_io_done), .o_io_dropped(o_io_dropped), .o_fot_reload(o_fot_reload),
  .o_cfg_rdata(o_cfg_rdata), .o_ior_n(o_ior_n), .o_iow_n(o_iow_n));

/* File: verif/io_recovery_control_top_test.sv */
// Self-checking bench for the I/O recovery timer
`timescale 1ns/1ns
module io_recovery_control_top_test;
  import io_recovery_control_pkg::*;
  logic clk = 0, clk_isa = 0, rst = 1, cfg_rd = 0, cfg_wr = 0, req = 0, wr = 0, wide = 0, sub = 0, go = 0;
  logic [7:0] cfg_a = 0, cfg_d = 0, rdata, gap, ncmd, n;
  logic [15:0] addr = 0, go_a = 0, isa_addr, last_a, m_addr;
  logic busy, done, drop, fot, claim, ior_n, iow_n, m_cmd, s_fot, s_drop, last_wr;
  int n_fail = 0, checks_done = 0;
  initial forever #4 clk = ~clk;
  initial begin
    #3;
    forever #24 clk_isa = ~clk_isa;
  end
  io_recovery_control_top #(.CMD_CYC(3)) dut_u (.i_clk_sys(clk), .i_clk_isa(clk_isa), .i_rst(rst), .i_cfg_rd(cfg_rd),
    .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_a), .i_cfg_wdata(cfg_d), .i_io_req(req), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_wide(wide), .i_io_sub(sub), .i_isam_cmd(m_cmd), .i_isam_addr(m_addr), .o_cfg_rdata(rdata),
    .o_io_busy(busy), .o_io_done(done), .o_io_dropped(drop), .o_fot_reload(fot), .o_isam_claim(claim),
    .o_ior_n(ior_n), .o_iow_n(iow_n), .o_isa_addr(isa_addr));
  io_recovery_control_isa_dev dev_u (.i_clk_isa(clk_isa), .i_ior_n(ior_n), .i_iow_n(iow_n), .i_isa_addr(isa_addr), .i_go(go),
    .i_go_addr(go_a), .o_cmd(m_cmd), .o_addr(m_addr), .o_gap(gap), .o_last_addr(last_a),
    .o_last_wr(last_wr), .o_n_cmd(ncmd));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {cfg_a, cfg_d, cfg_wr} = {a, d, 1'b1};
    @(posedge clk) #1;
    cfg_wr = 0;
    // Settle before the next cycle; the new byte goes to the link side copied with that request
    repeat (20) @(posedge clk);
  endtask
  task automatic cr(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    {cfg_a, cfg_rd} = {a, 1'b1};
    @(posedge clk) #1;
    cfg_rd = 0;
    chk("cfg", rdata, exp);
  endtask
  task automatic io(input logic [15:0] a, input logic w, input logic wd, input logic sb);
    @(posedge clk) #1;
    {addr, wr, wide, sub, req} = {a, w, wd, sb, 1'b1};
    @(posedge clk) #1;
    req = 0;
    s_fot = fot;
    for (int k = 0; k < 400 && done !== 1'b1; k++) @(posedge clk) #1;
    s_drop = drop;
    chk("done", done, 1);
  endtask
  task automatic mst(input logic [15:0] a, input logic exp);
    logic s;
    s = 0;
    go_a = a;
    go = 1;
    repeat (60) begin
      @(posedge clk) #1;
      s = s | claim;
      go = 0;
    end
    chk("claim", s, exp);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    cr(8'h0E, 8'h80);
    cw(8'h0E, 8'h00);
    cr(8'h0E, 8'h80);
    cr(8'h4C, 8'h4D);
    cr(8'h10, 8'h00);
    cw(8'h4C, 8'hC5);
    cr(8'h4C, 8'hC5);
  endtask
  task automatic t_gap;
    logic [7:0] cf[7] = '{8'h4D, 8'h4D, 8'h7D, 8'h7D, 8'h4F, 8'h03, 8'h03};
    logic [6:0] wd = 7'b1010010;
    logic [6:0] sb = 7'b0001000;
    int ex[7] = '{5, 5, 11, 4, 7, 4, 4};
    for (int i = 0; i < 7; i++) begin
      cw(8'h4C, cf[i]);
      io(16'h0300, 1, wd[i], sb[i]);
      io(16'h0301, 1, wd[i], sb[i]);
      chk("gap", gap, 16'(ex[i]));
    end
  endtask
  task automatic t_alias;
    cw(8'h4C, 8'h4D);
    io(16'h0095, 1, 0, 0);
    chk("alias wr", {s_fot, last_a}, 17'h10085);
    chk("dir wr", last_wr, 1);
    n = ncmd;
    io(16'h0095, 0, 0, 0);
    chk("alias rd", {s_drop, ncmd}, {1'b1, n});
    io(16'h0092, 0, 0, 0);
    chk("port 92", {s_drop, last_a}, 17'h00092);
    chk("dir rd", last_wr, 0);
    mst(16'h0095, 1);
    cw(8'h4C, 8'hCD);
    io(16'h0095, 0, 0, 0);
    chk("no alias", {s_fot, last_a}, 17'h00095);
    mst(16'h0095, 0);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_isa);
    // Release off both clock edges so neither domain races the reset
    @(posedge clk) #1;
    rst = 0;
    t_regs;
    t_gap;
    t_alias;
    end_sim;
  end
  initial begin
    #300000;
    n_fail++;
    end_sim;
  end
endmodule
